// ---- inc/amp_ctrl_pkg.sv ----
// Constants shared by the amplifier device control register bank
//
// Overview of operation
// - Switching-rate field picks PWM rate 768/384/480/576 kHz; other codes reserved.
// - Bridge bit clear gives bridge-tied output, set gives parallel bridge mono.
// - Modulation field: 00 two-level differential, 01 single-sided, 10 mixed idle.
// - Processor hold resets to 1; clearing it lets the processor run.
// - Mute bit ramps both channels' volume smoothly down, unmute ramps up.
// - Power request 00 deep sleep, 01 sleep, 11 play; resets to 00.
// - Power request 10 puts both output channels in high impedance together.
// - Wrap enabled, non-zero book page end continues at next page address 8.
// - Wrap disabled, page end wraps to address zero of same page.
// - Bit-clock ratio field: 0011=32, 0101=64, 0111=128, 1001=256, 1011=512 fs.
// - Sample-rate field 0000, its reset value, selects automatic rate detection.
`default_nettype none
package amp_ctrl_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_PAGE_SELECT   = 8'h00;
    localparam logic [7:0] OFS_OUTPUT_STAGE  = 8'h02;
    localparam logic [7:0] OFS_DEVICE_SECOND = 8'h03;
    localparam logic [7:0] OFS_PAGE_INC      = 8'h0F;
    localparam logic [7:0] OFS_AUDIO_CLOCK   = 8'h28;
    localparam logic [7:0] OFS_BOOK_SELECT   = 8'h7F;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_OUTPUT_STAGE  = 8'h00;
    localparam logic [7:0] RST_DEVICE_SECOND = 8'h10;
    localparam logic [7:0] RST_PAGE_INC      = 8'h00;
    localparam logic [7:0] RST_AUDIO_CLOCK   = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SWR_LSB    = 4;
    localparam int BRIDGE_BIT = 2;
    localparam int MOD_LSB    = 0;
    localparam int HOLD_BIT   = 4;
    localparam int MUTE_BIT   = 3;
    localparam int PSTATE_LSB = 0;
    localparam int WRAP_BIT   = 3;
    localparam int RATIO_LSB  = 4;
    localparam int FS_LSB     = 0;

    // ------------------------------------------------------------
    // Field codes
    // ------------------------------------------------------------
    localparam logic [2:0] SWR_768 = 3'h0;
    localparam logic [2:0] SWR_384 = 3'h1;
    localparam logic [2:0] SWR_480 = 3'h3;
    localparam logic [2:0] SWR_576 = 3'h4;
    localparam logic [1:0] PSTATE_DEEP  = 2'h0;
    localparam logic [1:0] PSTATE_SLEEP = 2'h1;
    localparam logic [1:0] PSTATE_HIZ   = 2'h2;
    localparam logic [1:0] PSTATE_PLAY  = 2'h3;
    localparam logic [3:0] RATIO_32  = 4'h3;
    localparam logic [3:0] RATIO_64  = 4'h5;
    localparam logic [3:0] RATIO_128 = 4'h7;
    localparam logic [3:0] RATIO_256 = 4'h9;
    localparam logic [3:0] RATIO_512 = 4'hB;
    localparam logic [3:0] FS_AUTO   = 4'h0;

    // ------------------------------------------------------------
    // Paging and timing
    // ------------------------------------------------------------
    localparam logic [7:0] PAGE_END        = 8'h7F;
    localparam logic [7:0] PAGE_NEXT_START = 8'h08;
    localparam logic [7:0] PAGE_START      = 8'h00;
    localparam logic [7:0] GAIN_FULL       = 8'hFF;
    localparam int CLK_KHZ        = 40000;
    localparam int RAMP_STEP_NS   = 1000;
    localparam int RAMP_STEP_CYC  = (RAMP_STEP_NS * CLK_KHZ + 999999) / 1000000;

    typedef enum logic [1:0] {
        GAIN_OPEN,
        GAIN_FALLING,
        GAIN_CLOSED,
        GAIN_RISING
    } ramp_state_t;

endpackage
`default_nettype wire

// ---- verilog/page_addr_stepper.sv ----
// Next register pointer after one auto-incrementing byte access
`timescale 1ns/10ps
`default_nettype none
module page_addr_stepper (
    input  wire logic [7:0] addr_in,
    input  wire logic [7:0] page_in,
    input  wire logic [7:0] book_in,
    input  wire logic       wrap_disable_in,
    output logic      [7:0] next_addr_out,
    output logic      [7:0] next_page_out
);

    // ------------------------------------------------------------
    // Page end handling
    // ------------------------------------------------------------
    wire at_end    = (addr_in == amp_ctrl_pkg::PAGE_END);
    // Book zero never advances page; only non-zero books do
    wire adv_page  = at_end && (book_in != 8'h00) && !wrap_disable_in;

    assign next_addr_out = !at_end ? 8'(addr_in + 8'h01) :
                           adv_page ? amp_ctrl_pkg::PAGE_NEXT_START
                                    : amp_ctrl_pkg::PAGE_START;
    assign next_page_out = adv_page ? 8'(page_in + 8'h01) : page_in;

endmodule // page_addr_stepper
`default_nettype wire

// ---- verilog/amp_device_control_regs.sv ----
// Device control register bank with pointer, paging and soft mute ramp
`timescale 1ns/10ps
`default_nettype none
module amp_device_control_regs #(
    parameter int RAMP_STEP_CYCLES = amp_ctrl_pkg::RAMP_STEP_CYC
) (
    input  wire logic       clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       addr_load_in,
    input  wire logic [7:0] addr_in,
    input  wire logic       wr_in,
    input  wire logic [7:0] wr_data_in,
    input  wire logic       rd_in,
    output logic      [7:0] rd_data_out,
    output logic      [7:0] addr_out,
    output logic      [7:0] page_out,
    output logic      [7:0] book_out,
    output logic      [2:0] switching_rate_select_out,
    output logic      [9:0] switching_rate_khz_out,
    output logic            bridge_parallel_select_out,
    output logic      [1:0] modulation_scheme_select_out,
    output logic            processor_hold_out,
    output logic            soft_mute_out,
    output logic      [7:0] mute_gain_out,
    output logic      [1:0] power_state_out,
    output logic            outputs_hiz_out,
    output logic            page_wrap_disable_out,
    output logic      [3:0] bitclock_frame_ratio_out,
    output logic      [9:0] bclk_per_frame_out,
    output logic      [3:0] sample_rate_select_out,
    output logic            sample_rate_auto_out
);

    logic [7:0] output_stage_config_reg;
    logic [7:0] device_control_second_reg;
    logic [7:0] page_increment_control_reg;
    logic [7:0] audio_clock_config_reg;
    logic [7:0] addr_reg;
    logic [7:0] page_reg;
    logic [7:0] book_reg;
    logic [7:0] step_addr;
    logic [7:0] step_page;
    logic [15:0] tick_cnt_reg;
    amp_ctrl_pkg::ramp_state_t ramp_reg;
    amp_ctrl_pkg::ramp_state_t ramp_next;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire in_base   = (book_reg == 8'h00) && (page_reg == 8'h00);
    wire hit_ctl1  = in_base && (addr_reg == amp_ctrl_pkg::OFS_OUTPUT_STAGE);
    wire hit_ctl2  = in_base && (addr_reg == amp_ctrl_pkg::OFS_DEVICE_SECOND);
    wire hit_pinc  = in_base && (addr_reg == amp_ctrl_pkg::OFS_PAGE_INC);
    wire hit_aclk  = in_base && (addr_reg == amp_ctrl_pkg::OFS_AUDIO_CLOCK);
    wire hit_page  = (addr_reg == amp_ctrl_pkg::OFS_PAGE_SELECT);
    wire hit_book  = (page_reg == 8'h00) &&
                     (addr_reg == amp_ctrl_pkg::OFS_BOOK_SELECT);
    wire step      = (wr_in || rd_in) && !addr_load_in;
    wire wrap_dis  = page_increment_control_reg[amp_ctrl_pkg::WRAP_BIT];
    wire tick      = (tick_cnt_reg == 16'(RAMP_STEP_CYCLES - 1));

    // Unmapped locations read as zero
    wire [7:0] rd_mux = hit_page ? page_reg :
                        hit_book ? book_reg :
                        hit_ctl1 ? output_stage_config_reg :
                        hit_ctl2 ? device_control_second_reg :
                        hit_pinc ? page_increment_control_reg :
                        hit_aclk ? audio_clock_config_reg : 8'h00;

    page_addr_stepper u_stepper (
        .addr_in         (addr_reg),
        .page_in         (page_reg),
        .book_in         (book_reg),
        .wrap_disable_in (wrap_dis),
        .next_addr_out   (step_addr),
        .next_page_out   (step_page)
    );

    // ------------------------------------------------------------
    // Pointer, page and book
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            addr_reg <= 8'h00;
            page_reg <= 8'h00;
            book_reg <= 8'h00;
        end else begin
            if (addr_load_in) begin
                addr_reg <= addr_in;
            end else if (step) begin
                addr_reg <= step_addr;
            end
            if (wr_in && !addr_load_in && hit_page) begin
                page_reg <= wr_data_in;
            end else if (step) begin
                page_reg <= step_page;
            end
            if (wr_in && !addr_load_in && hit_book) begin
                book_reg <= wr_data_in;
            end
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // Whole bytes are stored so reserved bits read back as written
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            output_stage_config_reg    <= amp_ctrl_pkg::RST_OUTPUT_STAGE;
            device_control_second_reg  <= amp_ctrl_pkg::RST_DEVICE_SECOND;
            page_increment_control_reg <= amp_ctrl_pkg::RST_PAGE_INC;
            audio_clock_config_reg     <= amp_ctrl_pkg::RST_AUDIO_CLOCK;
        end else if (wr_in && !addr_load_in) begin
            if (hit_ctl1) output_stage_config_reg <= wr_data_in;
            if (hit_ctl2) device_control_second_reg <= wr_data_in;
            if (hit_pinc) page_increment_control_reg <= wr_data_in;
            if (hit_aclk) audio_clock_config_reg <= wr_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rd_data_out <= 8'h00;
        end else if (rd_in && !addr_load_in) begin
            rd_data_out <= rd_mux;
        end
    end

    assign addr_out = addr_reg;
    assign page_out = page_reg;
    assign book_out = book_reg;
    assign switching_rate_select_out =
        output_stage_config_reg[amp_ctrl_pkg::SWR_LSB +: 3];
    assign bridge_parallel_select_out =
        output_stage_config_reg[amp_ctrl_pkg::BRIDGE_BIT];
    assign modulation_scheme_select_out =
        output_stage_config_reg[amp_ctrl_pkg::MOD_LSB +: 2];
    assign processor_hold_out =
        device_control_second_reg[amp_ctrl_pkg::HOLD_BIT];
    assign soft_mute_out = device_control_second_reg[amp_ctrl_pkg::MUTE_BIT];
    assign power_state_out =
        device_control_second_reg[amp_ctrl_pkg::PSTATE_LSB +: 2];
    assign page_wrap_disable_out = wrap_dis;
    assign bitclock_frame_ratio_out =
        audio_clock_config_reg[amp_ctrl_pkg::RATIO_LSB +: 4];
    assign sample_rate_select_out =
        audio_clock_config_reg[amp_ctrl_pkg::FS_LSB +: 4];

    // ------------------------------------------------------------
    // Decoded settings
    // ------------------------------------------------------------
    // A reserved rate code keeps the last valid rate rather than stopping
    wire [9:0] khz_next =
        (switching_rate_select_out == amp_ctrl_pkg::SWR_768) ? 10'h300 :
        (switching_rate_select_out == amp_ctrl_pkg::SWR_384) ? 10'h180 :
        (switching_rate_select_out == amp_ctrl_pkg::SWR_480) ? 10'h1E0 :
        (switching_rate_select_out == amp_ctrl_pkg::SWR_576) ? 10'h240 :
        switching_rate_khz_out;
    // Unlisted ratio codes decode to zero: no frame length known
    wire [9:0] bclk_next =
        (bitclock_frame_ratio_out == amp_ctrl_pkg::RATIO_32)  ? 10'h020 :
        (bitclock_frame_ratio_out == amp_ctrl_pkg::RATIO_64)  ? 10'h040 :
        (bitclock_frame_ratio_out == amp_ctrl_pkg::RATIO_128) ? 10'h080 :
        (bitclock_frame_ratio_out == amp_ctrl_pkg::RATIO_256) ? 10'h100 :
        (bitclock_frame_ratio_out == amp_ctrl_pkg::RATIO_512) ? 10'h200 :
        10'h000;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            switching_rate_khz_out <= 10'h300;
            bclk_per_frame_out     <= 10'h000;
            outputs_hiz_out        <= 1'b0;
            sample_rate_auto_out   <= 1'b1;
        end else begin
            switching_rate_khz_out <= khz_next;
            bclk_per_frame_out     <= bclk_next;
            outputs_hiz_out <= (power_state_out == amp_ctrl_pkg::PSTATE_HIZ);
            sample_rate_auto_out <=
                (sample_rate_select_out == amp_ctrl_pkg::FS_AUTO);
        end
    end

    // ------------------------------------------------------------
    // Soft mute ramp
    // ------------------------------------------------------------
    // One gain step per tick keeps the ramp free of clicks
    always_comb begin
        ramp_next = ramp_reg;
        case (ramp_reg)
            amp_ctrl_pkg::GAIN_OPEN: begin
                if (soft_mute_out) ramp_next = amp_ctrl_pkg::GAIN_FALLING;
            end
            amp_ctrl_pkg::GAIN_FALLING: begin
                if (!soft_mute_out) ramp_next = amp_ctrl_pkg::GAIN_RISING;
                else if (mute_gain_out == 8'h00) ramp_next = amp_ctrl_pkg::GAIN_CLOSED;
            end
            amp_ctrl_pkg::GAIN_CLOSED: begin
                if (!soft_mute_out) ramp_next = amp_ctrl_pkg::GAIN_RISING;
            end
            amp_ctrl_pkg::GAIN_RISING: begin
                if (soft_mute_out) ramp_next = amp_ctrl_pkg::GAIN_FALLING;
                else if (mute_gain_out == amp_ctrl_pkg::GAIN_FULL)
                    ramp_next = amp_ctrl_pkg::GAIN_OPEN;
            end
            default: ramp_next = amp_ctrl_pkg::GAIN_OPEN;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ramp_reg      <= amp_ctrl_pkg::GAIN_OPEN;
            tick_cnt_reg  <= 16'h0000;
            mute_gain_out <= amp_ctrl_pkg::GAIN_FULL;
        end else begin
            ramp_reg     <= ramp_next;
            tick_cnt_reg <= tick ? 16'h0000 : 16'(tick_cnt_reg + 16'h0001);
            if (tick && ramp_reg == amp_ctrl_pkg::GAIN_FALLING &&
                mute_gain_out != 8'h00) begin
                mute_gain_out <= 8'(mute_gain_out - 8'h01);
            end else if (tick && ramp_reg == amp_ctrl_pkg::GAIN_RISING &&
                         mute_gain_out != amp_ctrl_pkg::GAIN_FULL) begin
                mute_gain_out <= 8'(mute_gain_out + 8'h01);
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    sequence fall_step_s;
        ramp_reg == amp_ctrl_pkg::GAIN_FALLING && tick && mute_gain_out != 8'h00;
    endsequence
    sequence rise_step_s;
        ramp_reg == amp_ctrl_pkg::GAIN_RISING && tick &&
        mute_gain_out != amp_ctrl_pkg::GAIN_FULL;
    endsequence

    rate_decode_a: assert property (
        (switching_rate_select_out == 3'h1) |=> (switching_rate_khz_out == 10'h180))
        else $error("switching rate 001 not decoded to 384");
    bridge_write_a: assert property (
        (wr_in && !addr_load_in && hit_ctl1) |=>
        (bridge_parallel_select_out == $past(wr_data_in[2])))
        else $error("bridge bit did not follow write");
    mod_write_a: assert property (
        (wr_in && !addr_load_in && hit_ctl1) |=>
        (modulation_scheme_select_out == $past(wr_data_in[1:0])))
        else $error("modulation field did not follow write");
    hold_clear_a: assert property (
        (wr_in && !addr_load_in && hit_ctl2 && !wr_data_in[4]) |=>
        !processor_hold_out)
        else $error("processor hold not released");
    mute_fall_a: assert property (
        fall_step_s |=> (mute_gain_out == 8'($past(mute_gain_out) - 8'h01)))
        else $error("mute ramp did not step down");
    mute_rise_a: assert property (
        rise_step_s |=> (mute_gain_out == 8'($past(mute_gain_out) + 8'h01)))
        else $error("unmute ramp did not step up");
    hiz_both_a: assert property (
        (power_state_out == 2'h2) |=> outputs_hiz_out)
        else $error("high impedance not raised for code 10");
    wrap_next_a: assert property (
        (step && addr_reg == 8'h7F && book_reg != 8'h00 && !wrap_dis &&
         !(wr_in && hit_page)) |=>
        (addr_reg == 8'h08 && page_reg == 8'($past(page_reg) + 8'h01)))
        else $error("page end did not advance to next page");
    wrap_same_a: assert property (
        (step && addr_reg == 8'h7F && wrap_dis && !(wr_in && hit_page)) |=>
        (addr_reg == 8'h00 && $stable(page_reg)))
        else $error("page end did not wrap in page");
    ratio_decode_a: assert property (
        (bitclock_frame_ratio_out == 4'hB) |=> (bclk_per_frame_out == 10'h200))
        else $error("ratio 1011 not decoded to 512");
    auto_rate_a: assert property (
        (sample_rate_select_out == 4'h0) |=> sample_rate_auto_out)
        else $error("automatic rate detection not flagged");
    reserved_keep_a: assert property (
        (wr_in && !addr_load_in && hit_ctl2) |=>
        (device_control_second_reg == $past(wr_data_in)))
        else $error("written byte not held");

endmodule // amp_device_control_regs
`default_nettype wire

// ---- verif/host_ctrl_model.sv ----
// Host processor model that drives the register access port
`timescale 1ns/10ps
`default_nettype none
module host_ctrl_model #(
    parameter int SETTLE_CYCLES = 16
) (
    input  wire logic       clk_in,
    output logic            addr_load_out,
    output logic      [7:0] addr_out,
    output logic            wr_out,
    output logic      [7:0] wr_data_out,
    output logic            rd_out,
    input  wire logic [7:0] rd_data_in
);
    initial begin
        addr_load_out = 1'b0;
        addr_out      = 8'hA5;
        wr_out        = 1'b0;
        wr_data_out   = 8'h5A;
        rd_out        = 1'b0;
    end

    // ------------------------------------------------------------
    // Byte transfers, changed on the falling edge only
    // ------------------------------------------------------------
    task automatic load(input logic [7:0] a);
        @(negedge clk_in);
        addr_load_out = 1'b1;
        addr_out      = a;
        @(negedge clk_in);
        addr_load_out = 1'b0;
        // Idle bus shows a new pattern so a stale value cannot pass
        addr_out      = ~a;
    endtask

    task automatic wr(input logic [7:0] d);
        @(negedge clk_in);
        wr_out      = 1'b1;
        wr_data_out = d;
        @(negedge clk_in);
        wr_out      = 1'b0;
        wr_data_out = ~d;
    endtask

    task automatic rd(output logic [7:0] d);
        @(negedge clk_in);
        rd_out = 1'b1;
        @(negedge clk_in);
        rd_out = 1'b0;
        d      = rd_data_in;
    endtask

    // Extra edge lets decoded outputs that lag one cycle land
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        load(a);
        wr(d);
        @(negedge clk_in);
    endtask

    task automatic rreg(input logic [7:0] a, output logic [7:0] d);
        load(a);
        rd(d);
    endtask

    // Audio clocks get time to settle before the hold comes off
    task automatic release_hold(input logic [7:0] state);
        repeat (SETTLE_CYCLES) @(negedge clk_in);
        wreg(amp_ctrl_pkg::OFS_DEVICE_SECOND, state);
    endtask
endmodule // host_ctrl_model
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking testbench for the amplifier control register bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic       clk_in, rst_b_in, addr_load_in, wr_in, rd_in;
    logic [7:0] addr_in, wr_data_in, rd_data_out, addr_out, page_out;
    logic [7:0] book_out, mute_gain_out, d;
    logic [2:0] switching_rate_select_out;
    logic [9:0] switching_rate_khz_out, bclk_per_frame_out;
    logic [1:0] modulation_scheme_select_out, power_state_out;
    logic [3:0] bitclock_frame_ratio_out, sample_rate_select_out;
    logic       bridge_parallel_select_out, processor_hold_out;
    logic       soft_mute_out, outputs_hiz_out, page_wrap_disable_out;
    logic       sample_rate_auto_out;
    int         miscompares = 0;
    int         n_tests = 0;
    logic [7:0] rst_exp [3] = '{8'h00, 8'h10, 8'h00};
    logic [7:0] sw_byte [5] = '{8'h00, 8'h15, 8'h32, 8'h44, 8'hA8};
    logic [9:0] sw_khz  [5] = '{10'h300, 10'h180, 10'h1E0, 10'h240, 10'h240};
    logic [7:0] sc_byte [6] = '{8'h36, 8'h58, 8'h79, 8'h9A, 8'hBB, 8'h10};
    logic [9:0] sc_bclk [6] = '{10'h20, 10'h40, 10'h80, 10'h100, 10'h200,
                                10'h000};

    amp_device_control_regs #(.RAMP_STEP_CYCLES(2)) i_amp_device_control_regs (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .addr_load_in(addr_load_in),
        .addr_in(addr_in), .wr_in(wr_in), .wr_data_in(wr_data_in),
        .rd_in(rd_in), .rd_data_out(rd_data_out), .addr_out(addr_out),
        .page_out(page_out), .book_out(book_out),
        .switching_rate_select_out(switching_rate_select_out),
        .switching_rate_khz_out(switching_rate_khz_out),
        .bridge_parallel_select_out(bridge_parallel_select_out),
        .modulation_scheme_select_out(modulation_scheme_select_out),
        .processor_hold_out(processor_hold_out),
        .soft_mute_out(soft_mute_out), .mute_gain_out(mute_gain_out),
        .power_state_out(power_state_out),
        .outputs_hiz_out(outputs_hiz_out),
        .page_wrap_disable_out(page_wrap_disable_out),
        .bitclock_frame_ratio_out(bitclock_frame_ratio_out),
        .bclk_per_frame_out(bclk_per_frame_out),
        .sample_rate_select_out(sample_rate_select_out),
        .sample_rate_auto_out(sample_rate_auto_out));

    host_ctrl_model i_host_ctrl_model (
        .clk_in(clk_in), .addr_load_out(addr_load_in), .addr_out(addr_in),
        .wr_out(wr_in), .wr_data_out(wr_data_in), .rd_out(rd_in),
        .rd_data_in(rd_data_out));

    // ------------------------------------------------------------
    // Clock, checking and closing
    // ------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    task automatic chk(input string what, input logic [9:0] exp,
                       input logic [9:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic wait_gain(input logic [7:0] target);
        for (int n = 0; n < 600 && mute_gain_out !== target; n++) begin
            @(negedge clk_in);
        end
        chk("gain end", {2'h0, target}, {2'h0, mute_gain_out});
    endtask

    task automatic summarize();
        $display("Counts: %0d checks, %0d miscompares", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Whole run needs about 1200 cycles, so 20000 means a hang
    initial begin
        #(25 * 20000);
        miscompares++;
        summarize();
    end

    initial begin
        rst_b_in = 1'b0;
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        rst_b_in = 1'b1;
        chk("hold", 10'h1, {9'h0, processor_hold_out});
        chk("auto", 10'h1, {9'h0, sample_rate_auto_out});
        i_host_ctrl_model.load(8'h02);
        for (int i = 0; i < 3; i++) begin
            i_host_ctrl_model.rd(d);
            chk("reset byte", {2'h0, rst_exp[i]}, {2'h0, d});
        end
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            i_host_ctrl_model.wreg(8'h02, sw_byte[i]);
            chk("khz", sw_khz[i], switching_rate_khz_out);
            chk("swsel", {7'h0, sw_byte[i][6:4]},
                {7'h0, switching_rate_select_out});
            chk("bridge", {9'h0, sw_byte[i][2]},
                {9'h0, bridge_parallel_select_out});
            chk("mod", {8'h0, sw_byte[i][1:0]},
                {8'h0, modulation_scheme_select_out});
            i_host_ctrl_model.rreg(8'h02, d);
            chk("stage byte", {2'h0, sw_byte[i]}, {2'h0, d});
        end
        $display("test output stage done");
        for (int i = 0; i < 6; i++) begin
            i_host_ctrl_model.wreg(8'h28, sc_byte[i]);
            chk("bclk", sc_bclk[i], bclk_per_frame_out);
            chk("ratio", {6'h0, sc_byte[i][7:4]},
                {6'h0, bitclock_frame_ratio_out});
            chk("fs", {6'h0, sc_byte[i][3:0]},
                {6'h0, sample_rate_select_out});
            chk("auto", {9'h0, sc_byte[i][3:0] == 4'h0},
                {9'h0, sample_rate_auto_out});
        end
        $display("test audio clock done");
        for (int p = 0; p < 4; p++) begin
            i_host_ctrl_model.wreg(8'h03, 8'h10 | 8'(p));
            chk("pstate", 10'(p), {8'h0, power_state_out});
            chk("hiz", {9'h0, p == 2}, {9'h0, outputs_hiz_out});
            chk("hold", 10'h1, {9'h0, processor_hold_out});
        end
        i_host_ctrl_model.release_hold(8'h03);
        chk("hold", 10'h0, {9'h0, processor_hold_out});
        $display("test power state done");
        i_host_ctrl_model.wreg(8'h03, 8'h0B);
        repeat (6) @(negedge clk_in);
        chk("mute", 10'h1, {9'h0, soft_mute_out});
        chk("gain mid", 10'h1, {9'h0, mute_gain_out < 8'hFF &&
            mute_gain_out > 8'hF0});
        wait_gain(8'h00);
        i_host_ctrl_model.wreg(8'h03, 8'h03);
        wait_gain(8'hFF);
        $display("test soft mute done");
        i_host_ctrl_model.wreg(8'h7F, 8'h01);
        i_host_ctrl_model.wreg(8'h00, 8'h02);
        i_host_ctrl_model.rreg(8'h7F, d);
        chk("refused", 10'h0, {2'h0, d});
        chk("next addr", 10'h08, {2'h0, addr_out});
        chk("next page", 10'h03, {2'h0, page_out});
        chk("book", 10'h01, {2'h0, book_out});
        i_host_ctrl_model.wreg(8'h00, 8'h00);
        i_host_ctrl_model.wreg(8'h7F, 8'h00);
        // Book was still non-zero at that page end, so the page moved on
        chk("book clear", 10'h00, {2'h0, book_out});
        chk("page moved", 10'h01, {2'h0, page_out});
        i_host_ctrl_model.wreg(8'h00, 8'h00);
        i_host_ctrl_model.wreg(8'h0F, 8'hF8);
        i_host_ctrl_model.rreg(8'h0F, d);
        chk("wrap byte", 10'h0F8, {2'h0, d});
        chk("wrap bit", 10'h1, {9'h0, page_wrap_disable_out});
        i_host_ctrl_model.wreg(8'h7F, 8'h01);
        i_host_ctrl_model.wreg(8'h00, 8'h02);
        i_host_ctrl_model.rreg(8'h7F, d);
        chk("wrap addr", 10'h00, {2'h0, addr_out});
        chk("wrap page", 10'h02, {2'h0, page_out});
        $display("test paging done");
        summarize();
    end
endmodule // tb_top
`default_nettype wire
